// ---- design/ufi_endpoint_fifo.sv ----
// Function
// - FIFO reset zeroes the endpoint pointer, received count and data toggle.
// - Software resets endpoint n by writing bit n as 1, then 0.
// - FIFO reset leaves the ping-pong bank number unchanged.
// - The data register reaches the FIFO of the selected endpoint.
// - A valid OUT packet fills the FIFO and updates the received count.
// - Reading the FIFO leaves the received count unchanged.
// - Each data register read advances the selected endpoint pointer.
// - Each data register write stores the byte and advances the pointer.
// - Writing the FIFO leaves the byte counter unchanged.
// - Setting transmit-ready queues the bank and switches to the other bank.
// - IN requests to a bank without transmit-ready get a NAK.
// - Host acknowledge sets transmit-complete and raises the interrupt if enabled.
`timescale 1ns/1ps
`default_nettype none
module ufi_endpoint_fifo #(
	parameter int DEPTH = 64
) (
	input  wire logic                              aclk,
	input  wire logic                              aresetn,
	input  wire logic [7:0]                        s_axi_awaddr,
	input  wire logic                              s_axi_awvalid,
	output logic                                   s_axi_awready,
	input  wire logic [31:0]                       s_axi_wdata,
	input  wire logic [3:0]                        s_axi_wstrb,
	input  wire logic                              s_axi_wvalid,
	output logic                                   s_axi_wready,
	output logic [1:0]                             s_axi_bresp,
	output logic                                   s_axi_bvalid,
	input  wire logic                              s_axi_bready,
	input  wire logic [7:0]                        s_axi_araddr,
	input  wire logic                              s_axi_arvalid,
	output logic                                   s_axi_arready,
	output logic [31:0]                            s_axi_rdata,
	output logic [1:0]                             s_axi_rresp,
	output logic                                   s_axi_rvalid,
	input  wire logic                              s_axi_rready,
	input  wire logic                              rx_byte_valid,
	input  wire ufi_pkg::ufi_rx_byte_t             rx_byte,
	input  wire logic                              rx_end_valid,
	input  wire ufi_pkg::ufi_rx_end_t              rx_end,
	input  wire logic                              in_req,
	input  wire logic [ufi_pkg::EP_W-1:0]          in_req_ep,
	output logic                                   in_go,
	output logic                                   in_nak,
	output logic [$clog2(DEPTH):0]                 in_len,
	input  wire logic                              tx_rd,
	output logic [7:0]                             tx_byte,
	input  wire logic                              in_acked,
	output logic [ufi_pkg::NUM_EP-1:0]             data_toggle,
	output logic                                   irq
);
	localparam int PW = $clog2(DEPTH);
	localparam int NE = ufi_pkg::NUM_EP;

	// every assertion below runs on aclk and rests during reset
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	logic [7:0]               mem [NE][2][DEPTH];
	logic [PW:0]              ptr [NE];
	logic [15:0]              count [NE];
	logic [PW:0]              len [NE][2];
	logic [NE-1:0]            cbank;
	logic [NE-1:0]            tbank;
	logic [NE-1:0]            rdy0;
	logic [NE-1:0]            rdy1;
	logic [NE-1:0]            cmpl;
	logic [NE-1:0]            enable;
	logic [NE-1:0]            fifo_rst;
	logic [ufi_pkg::EP_W-1:0] sel;
	logic [2*NE-1:0]          int_status;
	logic [2*NE-1:0]          int_mask;
	logic [2*NE-1:0]          int_set;
	logic [PW:0]              rx_wptr;
	logic [PW:0]              tx_ptr;
	logic [ufi_pkg::EP_W-1:0] tx_ep;
	logic                     aw_held;
	logic                     w_held;
	logic [7:0]               waddr;
	logic [31:0]              wdata;
	logic [3:0]               wstrb;
	logic                     wr_fire;
	logic                     wr_en;
	logic                     rd_fire;
	logic [31:0]              rd_val;
	logic                     rd_ok;
	logic                     wr_ok;
	logic                     cpu_wr_data;
	logic                     cpu_rd_data;
	logic                     cpu_set_rdy;
	logic                     cpu_clr_cmpl;
	logic [7:0]               sel_byte;

	// write channel capture, both orders accepted
	assign s_axi_awready = !aw_held && !s_axi_bvalid;
	assign s_axi_wready  = !w_held && !s_axi_bvalid;
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_held <= 1'b0;
			w_held  <= 1'b0;
			waddr   <= 8'h00;
			wdata   <= 32'h0000_0000;
			wstrb   <= 4'h0;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				aw_held <= 1'b1;
				waddr   <= s_axi_awaddr;
			end
			else if (wr_fire)
				aw_held <= 1'b0;
			if (s_axi_wvalid && s_axi_wready)
			begin
				w_held <= 1'b1;
				wdata  <= s_axi_wdata;
				wstrb  <= s_axi_wstrb;
			end
			else if (wr_fire)
				w_held <= 1'b0;
		end
	end

	// write decode
	assign wr_fire = aw_held && w_held;
	assign wr_ok   = waddr[7:5] == 3'h0 && waddr[1:0] == 2'h0;
	assign wr_en   = wr_fire && wr_ok && wstrb[0];
	assign cpu_wr_data  = wr_en && waddr == ufi_pkg::ADDR_FIFO_DATA;
	assign cpu_set_rdy  = wr_en && waddr == ufi_pkg::ADDR_EP_STATUS
		&& wdata[ufi_pkg::STA_TRANSMIT_READY_FLAG_BIT];
	assign cpu_clr_cmpl = wr_en && waddr == ufi_pkg::ADDR_EP_STATUS
		&& wdata[ufi_pkg::STA_TRANSMIT_COMPLETE_FLAG_BIT];

	// write response, one cycle after both halves are held
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_bvalid <= 1'b0;
			s_axi_bresp  <= ufi_pkg::RESP_OKAY;
		end
		else if (wr_fire)
		begin
			s_axi_bvalid <= 1'b1;
			s_axi_bresp  <= wr_ok ? ufi_pkg::RESP_OKAY : ufi_pkg::RESP_SLVERR;
		end
		else if (s_axi_bready)
			s_axi_bvalid <= 1'b0;
	end

	// plain control registers
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sel      <= ufi_pkg::RST_EP_SELECT;
			fifo_rst <= ufi_pkg::RST_EP_VEC;
			enable   <= ufi_pkg::RST_EP_VEC;
			int_mask <= '0;
		end
		else if (wr_en)
		begin
			unique case (waddr)
				ufi_pkg::ADDR_EP_SELECT:  sel <= wdata[ufi_pkg::EP_W-1:0];
				ufi_pkg::ADDR_FIFO_RESET: fifo_rst <= wdata[NE-1:0];
				ufi_pkg::ADDR_EP_CONTROL: enable[sel] <= wdata[ufi_pkg::CTL_ENABLE_BIT];
				ufi_pkg::ADDR_INT_MASK:   int_mask <= wdata[2*NE-1:0];
				default: ;
			endcase
		end
	end

	// read side, data registered one cycle after the address
	assign s_axi_arready = !s_axi_rvalid;
	assign rd_fire       = s_axi_arvalid && s_axi_arready;
	assign cpu_rd_data   = rd_fire && s_axi_araddr == ufi_pkg::ADDR_FIFO_DATA;
	assign sel_byte      = mem[sel][cbank[sel]][ptr[sel][PW-1:0]];
	always_comb
	begin
		rd_val = 32'h0000_0000;
		rd_ok  = 1'b1;
		unique case (s_axi_araddr)
			ufi_pkg::ADDR_EP_SELECT:  rd_val[ufi_pkg::EP_W-1:0] = sel;
			ufi_pkg::ADDR_FIFO_RESET: rd_val[NE-1:0] = fifo_rst;
			ufi_pkg::ADDR_FIFO_DATA:  rd_val[7:0] = sel_byte;
			ufi_pkg::ADDR_RX_COUNT:   rd_val[15:0] = count[sel];
			ufi_pkg::ADDR_EP_CONTROL:
			begin
				rd_val[ufi_pkg::CTL_TOGGLE_BIT] = data_toggle[sel];
				rd_val[ufi_pkg::CTL_ENABLE_BIT] = enable[sel];
			end
			ufi_pkg::ADDR_EP_STATUS:
			begin
				rd_val[ufi_pkg::STA_TRANSMIT_READY_FLAG_BIT]  = cbank[sel] ? rdy1[sel] : rdy0[sel];
				rd_val[ufi_pkg::STA_TRANSMIT_COMPLETE_FLAG_BIT] = cmpl[sel];
				rd_val[ufi_pkg::STA_BANK_BIT]   = cbank[sel];
			end
			ufi_pkg::ADDR_INT_STATUS: rd_val[2*NE-1:0] = int_status;
			ufi_pkg::ADDR_INT_MASK:   rd_val[2*NE-1:0] = int_mask;
			default:                  rd_ok = 1'b0;
		endcase
	end
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			s_axi_rvalid <= 1'b0;
			s_axi_rdata  <= 32'h0000_0000;
			s_axi_rresp  <= ufi_pkg::RESP_OKAY;
		end
		else if (rd_fire)
		begin
			s_axi_rvalid <= 1'b1;
			s_axi_rdata  <= rd_val;
			s_axi_rresp  <= rd_ok ? ufi_pkg::RESP_OKAY : ufi_pkg::RESP_SLVERR;
		end
		else if (s_axi_rready)
			s_axi_rvalid <= 1'b0;
	end

	// fifo storage: cpu fills in endpoints, engine fills out endpoints
	always_ff @(posedge aclk)
	begin
		if (cpu_wr_data)
			mem[sel][cbank[sel]][ptr[sel][PW-1:0]] <= wdata[7:0];
		if (rx_byte_valid)
			mem[rx_byte.ep][1'b0][rx_wptr[PW-1:0]] <= rx_byte.data;
	end

	// out packet write pointer
	always_ff @(posedge aclk)
	begin
		if (!aresetn || rx_end_valid)
			rx_wptr <= '0;
		else if (rx_byte_valid)
			rx_wptr <= rx_wptr + 1'b1;
	end

	// in request answer and byte delivery
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			in_go   <= 1'b0;
			in_nak  <= 1'b0;
			in_len  <= '0;
			tx_ep   <= '0;
			tx_ptr  <= '0;
			tx_byte <= 8'h00;
		end
		else
		begin
			in_go  <= 1'b0;
			in_nak <= 1'b0;
			if (in_req)
			begin
				if (enable[in_req_ep] && (tbank[in_req_ep] ? rdy1[in_req_ep] : rdy0[in_req_ep]))
				begin
					in_go  <= 1'b1;
					in_len <= len[in_req_ep][tbank[in_req_ep]];
					tx_ep  <= in_req_ep;
					tx_ptr <= '0;
				end
				else
					in_nak <= 1'b1;
			end
			else if (tx_rd)
			begin
				tx_byte <= mem[tx_ep][tbank[tx_ep]][tx_ptr[PW-1:0]];
				tx_ptr  <= tx_ptr + 1'b1;
			end
		end
	end

	// per endpoint state
	for (genvar e = 0; e < NE; e++)
	begin : g_ep
		logic hit;
		logic acked;
		logic rx_done;
		localparam logic [ufi_pkg::EP_W-1:0] EID = (ufi_pkg::EP_W)'(e); // endpoint number
		assign hit     = sel == EID;
		assign acked   = in_acked && tx_ep == EID;
		assign rx_done = rx_end_valid && rx_end.ok && rx_end.ep == EID;
		assign int_set[e]    = acked;
		assign int_set[NE+e] = rx_done;

		// address vector
		always_ff @(posedge aclk)
		begin
			if (!aresetn || fifo_rst[e])
				ptr[e] <= '0;
			else if (rx_done || (hit && cpu_set_rdy))
				ptr[e] <= '0;
			else if (hit && (cpu_rd_data || cpu_wr_data))
				ptr[e] <= ptr[e] + 1'b1;
		end

		// received byte count, untouched by fifo access
		always_ff @(posedge aclk)
		begin
			if (!aresetn || fifo_rst[e])
				count[e] <= ufi_pkg::RST_COUNT;
			else if (rx_done)
				count[e] <= 16'(rx_wptr);
		end

		// data toggle
		always_ff @(posedge aclk)
		begin
			if (!aresetn || fifo_rst[e])
				data_toggle[e] <= 1'b0;
			else if (rx_done || acked)
				data_toggle[e] <= !data_toggle[e];
		end

		// ping-pong banks, not touched by fifo reset
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
			begin
				cbank[e] <= 1'b0;
				tbank[e] <= 1'b0;
				rdy0[e]  <= 1'b0;
				rdy1[e]  <= 1'b0;
				len[e][0] <= '0;
				len[e][1] <= '0;
			end
			else
			begin
				if (hit && cpu_set_rdy)
				begin
					cbank[e] <= !cbank[e];
					len[e][cbank[e]] <= ptr[e];
				end
				if (acked)
					tbank[e] <= !tbank[e];
				if (hit && cpu_set_rdy && !cbank[e])
					rdy0[e] <= 1'b1;
				else if (acked && !tbank[e])
					rdy0[e] <= 1'b0;
				if (hit && cpu_set_rdy && cbank[e])
					rdy1[e] <= 1'b1;
				else if (acked && tbank[e])
					rdy1[e] <= 1'b0;
			end
		end

		// transmit complete, set wins over clear
		always_ff @(posedge aclk)
		begin
			if (!aresetn)
				cmpl[e] <= 1'b0;
			else if (acked)
				cmpl[e] <= 1'b1;
			else if (hit && cpu_clr_cmpl)
				cmpl[e] <= 1'b0;
		end

		a_reset_clears_ep: assert property (
			fifo_rst[e] |=> ptr[e] == '0 && count[e] == 16'h0000 && !data_toggle[e])
			else $error("fifo reset left endpoint state");
		a_reset_keeps_bank: assert property (
			fifo_rst[e] && !(hit && cpu_set_rdy) |=> $stable(cbank[e]))
			else $error("fifo reset moved the bank");
		a_read_keeps_count: assert property (
			hit && cpu_rd_data && !rx_done && !fifo_rst[e] |=> $stable(count[e]))
			else $error("fifo read changed count");
		a_write_keeps_count: assert property (
			hit && cpu_wr_data && !rx_done && !fifo_rst[e] |=> $stable(count[e]))
			else $error("fifo write changed count");
		a_access_moves_ptr: assert property (
			hit && (cpu_rd_data || cpu_wr_data) && !rx_done && !fifo_rst[e] && !cpu_set_rdy
			|=> ptr[e] == $past(ptr[e]) + 1'b1)
			else $error("pointer did not advance");
		a_ready_flips_bank: assert property (
			hit && cpu_set_rdy |=> cbank[e] != $past(cbank[e]) && ptr[e] == '0)
			else $error("bank not switched on ready");
	end

	// sticky interrupt status, write one to clear, set wins
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
			int_status <= '0;
		else if (wr_en && waddr == ufi_pkg::ADDR_INT_STATUS)
			int_status <= (int_status & ~wdata[2*NE-1:0]) | int_set;
		else
			int_status <= int_status | int_set;
	end
	assign irq = |(int_status & int_mask);

	sequence s_host_ack;
		in_acked && int_mask[tx_ep];
	endsequence
	sequence s_flag_then_irq;
		cmpl[$past(tx_ep)] ##0 irq;
	endsequence

	a_ack_raises_irq: assert property (s_host_ack |=> s_flag_then_irq)
		else $error("ack did not raise interrupt");
	a_nak_when_unready: assert property (
		in_req && !(tbank[in_req_ep] ? rdy1[in_req_ep] : rdy0[in_req_ep])
		|=> in_nak && !in_go)
		else $error("unready bank not refused");
	a_data_read_selected: assert property (
		cpu_rd_data |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(sel_byte))
		else $error("data read wrong endpoint byte");
	a_rx_sets_count: assert property (
		rx_end_valid && rx_end.ok && !fifo_rst[rx_end.ep]
		|=> count[$past(rx_end.ep)] == 16'($past(rx_wptr)))
		else $error("received count not updated");
	a_reset_write_pair: assert property (
		wr_en && waddr == ufi_pkg::ADDR_FIFO_RESET |=> fifo_rst == $past(wdata[NE-1:0]))
		else $error("reset register not loaded");
endmodule // ufi_endpoint_fifo
`default_nettype wire

// ---- design/ufi_pkg.sv ----
`default_nettype none
package ufi_pkg;
	// endpoint numbering
	localparam int EP_W   = 2;
	localparam int NUM_EP = 4;

	// register byte offsets
	localparam logic [7:0] ADDR_EP_SELECT  = 8'h00;
	localparam logic [7:0] ADDR_FIFO_RESET = 8'h04;
	localparam logic [7:0] ADDR_FIFO_DATA  = 8'h08;
	localparam logic [7:0] ADDR_RX_COUNT   = 8'h0C;
	localparam logic [7:0] ADDR_EP_CONTROL = 8'h10;
	localparam logic [7:0] ADDR_EP_STATUS  = 8'h14;
	localparam logic [7:0] ADDR_INT_STATUS = 8'h18;
	localparam logic [7:0] ADDR_INT_MASK   = 8'h1C;

	// field positions
	localparam int CTL_TOGGLE_BIT = 0;
	localparam int CTL_ENABLE_BIT = 1;
	localparam int STA_TRANSMIT_READY_FLAG_BIT  = 0;
	localparam int STA_TRANSMIT_COMPLETE_FLAG_BIT = 1;
	localparam int STA_BANK_BIT   = 2;

	// values after reset
	localparam logic [EP_W-1:0]   RST_EP_SELECT = 2'h0;
	localparam logic [NUM_EP-1:0] RST_EP_VEC    = 4'h0;
	localparam logic [15:0]       RST_COUNT     = 16'h0000;

	// axi responses
	localparam logic [1:0] RESP_OKAY   = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	// one byte from the serial engine into an out endpoint
	typedef struct packed {
		logic [EP_W-1:0] ep;
		logic [7:0]      data;
	} ufi_rx_byte_t;

	// end of an out packet
	typedef struct packed {
		logic [EP_W-1:0] ep;
		logic            ok;
	} ufi_rx_end_t;
endpackage
`default_nettype wire

// ---- verif/ufi_engine_model.sv ----
`timescale 1ns/1ps
`default_nettype none
// serial engine stand-in; drives right after a rising edge
module ufi_engine_model #(
	parameter int DEPTH = 8
) (
	input  wire logic                    aclk,
	output var logic                     rx_byte_valid,
	output var ufi_pkg::ufi_rx_byte_t    rx_byte,
	output var logic                     rx_end_valid,
	output var ufi_pkg::ufi_rx_end_t     rx_end,
	output var logic                     in_req,
	output var logic [ufi_pkg::EP_W-1:0] in_req_ep,
	input  wire logic                    in_go,
	input  wire logic                    in_nak,
	input  wire logic [$clog2(DEPTH):0]  in_len,
	output var logic                     tx_rd,
	input  wire logic [7:0]              tx_byte,
	output var logic                     in_acked
);
	// quiet lines at time zero
	initial
	begin
		rx_byte_valid = 1'b0;
		rx_byte = '0;
		rx_end_valid = 1'b0;
		rx_end = '0;
		in_req = 1'b0;
		in_req_ep = '0;
		tx_rd = 1'b0;
		in_acked = 1'b0;
	end

	// out packet: n bytes counting up, then the end marker
	task automatic out_pkt(input logic [1:0] ep, input int n, input logic [7:0] f,
		input logic ok);
		for (int i = 0; i < n; i++)
		begin
			@(posedge aclk);
			rx_byte_valid <= 1'b1;
			rx_byte <= '{ep: ep, data: f + 8'(i)};
		end
		@(posedge aclk);
		rx_byte_valid <= 1'b0;
		rx_byte.data <= ~rx_byte.data; // no stale byte once released
		rx_end_valid <= 1'b1;
		rx_end <= '{ep: ep, ok: ok};
		@(posedge aclk);
		rx_end_valid <= 1'b0;
		rx_end.ok <= ~ok;
	endtask

	// in token; answer sampled the cycle after
	task automatic in_token(input logic [1:0] ep, output logic go, output logic nak,
		output logic [$clog2(DEPTH):0] len);
		@(posedge aclk);
		in_req <= 1'b1;
		in_req_ep <= ep;
		@(posedge aclk);
		in_req <= 1'b0;
		in_req_ep <= ~ep;
		@(negedge aclk);
		go = in_go;
		nak = in_nak;
		len = in_len;
	endtask

	// fetch one in byte
	task automatic tx_fetch(output logic [7:0] b);
		@(posedge aclk);
		tx_rd <= 1'b1;
		@(posedge aclk);
		tx_rd <= 1'b0;
		@(negedge aclk);
		b = tx_byte;
	endtask

	// host ack, possibly late
	task automatic ack(input int w);
		repeat (w) @(posedge aclk);
		@(posedge aclk);
		in_acked <= 1'b1;
		@(posedge aclk);
		in_acked <= 1'b0;
	endtask
endmodule // ufi_engine_model
`default_nettype wire

// ---- verif/usb_endpoint_fifo_interface_test.sv ----
`timescale 1ns/1ps
`default_nettype none
module usb_endpoint_fifo_interface_test;
	logic                  aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
	logic                  arvalid, arready, rvalid, rready, go, nak, irq;
	logic                  rx_byte_valid, rx_end_valid, in_req, in_go, in_nak, tx_rd, in_acked;
	logic [7:0]            awaddr, araddr, tx_byte, b;
	logic [31:0]           wdata, rdata;
	logic [3:0]            wstrb, in_len, len, data_toggle;
	logic [1:0]            bresp, rresp, in_req_ep, r;
	ufi_pkg::ufi_rx_byte_t rx_byte;
	ufi_pkg::ufi_rx_end_t  rx_end;
	int                    bad_count, cmp_count, cyc;

	// 25 MHz clock
	always #20 aclk = ~aclk;

	ufi_endpoint_fifo #(.DEPTH(8)) i_dut (.aclk(aclk), .aresetn(aresetn),
		.s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
		.s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
		.s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
		.s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
		.s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
		.s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte), .rx_end_valid(rx_end_valid), .rx_end(rx_end), .in_req(in_req),
		.in_req_ep(in_req_ep), .in_go(in_go), .in_nak(in_nak), .in_len(in_len),
		.tx_rd(tx_rd), .tx_byte(tx_byte), .in_acked(in_acked),
		.data_toggle(data_toggle), .irq(irq));

	ufi_engine_model #(.DEPTH(8)) i_eng (.aclk(aclk), .rx_byte_valid(rx_byte_valid),
		.rx_byte(rx_byte), .rx_end_valid(rx_end_valid), .rx_end(rx_end), .in_req(in_req),
		.in_req_ep(in_req_ep), .in_go(in_go), .in_nak(in_nak), .in_len(in_len),
		.tx_rd(tx_rd), .tx_byte(tx_byte), .in_acked(in_acked));

	// counts every compare, reports a miss at once
	task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e)
		begin
			bad_count++;
			$display("MISMATCH %s exp %h got %h", n, e, g);
		end
	endtask

	// axi write, both halves offered together
	task automatic axw(input logic [7:0] a, input logic [31:0] d, output logic [1:0] rs);
		logic ta, tw, tb;
		@(posedge aclk);
		awaddr <= a;
		awvalid <= 1'b1;
		wdata <= d;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do
		begin
			@(negedge aclk);
			ta = awvalid & awready;
			tw = wvalid & wready;
			tb = bvalid & bready;
			rs = bresp;
			@(posedge aclk);
			if (ta)
				awvalid <= 1'b0;
			if (tw)
				wvalid <= 1'b0;
		end
		while (!tb);
		bready <= 1'b0;
	endtask

	// axi read
	task automatic axr(input logic [7:0] a, output logic [31:0] d, output logic [1:0] rs);
		logic tr, tv;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do
		begin
			@(negedge aclk);
			tr = arvalid & arready;
			tv = rvalid & rready;
			d = rdata;
			rs = rresp;
			@(posedge aclk);
			if (tr)
				arvalid <= 1'b0;
		end
		while (!tv);
		rready <= 1'b0;
	endtask

	// write expecting an okay answer
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		axw(a, d, r);
		chk("bresp", 32'h0000_0000, 32'(r));
	endtask

	// read and compare
	task automatic rd(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] d;
		axr(a, d, r);
		chk("rresp", 32'h0000_0000, 32'(r));
		chk(n, e, d);
	endtask

	// reset values and unmapped places
	task automatic t_reset();
		logic [31:0] d;
		rd("select", ufi_pkg::ADDR_EP_SELECT, 32'h0000_0000);
		rd("count", ufi_pkg::ADDR_RX_COUNT, 32'h0000_0000);
		rd("status", ufi_pkg::ADDR_EP_STATUS, 32'h0000_0000);
		rd("int_status", ufi_pkg::ADDR_INT_STATUS, 32'h0000_0000);
		axr(8'h20, d, r);
		chk("unmapped rresp", 32'(ufi_pkg::RESP_SLVERR), 32'(r));
		chk("unmapped rdata", 32'h0000_0000, d);
		axw(8'h24, 32'h0000_00ff, r);
		chk("unmapped bresp", 32'(ufi_pkg::RESP_SLVERR), 32'(r));
		chk("irq", 32'h0000_0000, 32'(irq));
	endtask

	// out packet on endpoint 1, read back, interrupt, fifo reset
	task automatic t_out();
		wr(ufi_pkg::ADDR_EP_SELECT, 32'h0000_0001);
		i_eng.out_pkt(2'h1, 3, 8'ha0, 1'b1);
		// bad packet elsewhere: no count, toggle or interrupt may follow
		i_eng.out_pkt(2'h0, 2, 8'h55, 1'b0);
		rd("count", ufi_pkg::ADDR_RX_COUNT, 32'h0000_0003);
		for (int i = 0; i < 3; i++)
			rd("out byte", ufi_pkg::ADDR_FIFO_DATA, 32'(8'ha0 + i));
		rd("count", ufi_pkg::ADDR_RX_COUNT, 32'h0000_0003);
		chk("toggle", 32'h0000_0002, 32'(data_toggle));
		rd("int_status", ufi_pkg::ADDR_INT_STATUS, 32'h0000_0020);
		wr(ufi_pkg::ADDR_INT_MASK, 32'h0000_0020);
		@(negedge aclk);
		chk("irq on", 32'h0000_0001, 32'(irq));
		wr(ufi_pkg::ADDR_INT_STATUS, 32'h0000_0020);
		@(negedge aclk);
		chk("irq off", 32'h0000_0000, 32'(irq));
		wr(ufi_pkg::ADDR_FIFO_RESET, 32'h0000_0002);
		wr(ufi_pkg::ADDR_FIFO_RESET, 32'h0000_0000);
		rd("count", ufi_pkg::ADDR_RX_COUNT, 32'h0000_0000);
		chk("toggle", 32'h0000_0000, 32'(data_toggle));
		rd("first byte", ufi_pkg::ADDR_FIFO_DATA, 32'h0000_00a0);
	endtask

	// in transfer on endpoint 2 from bank 0, then a nak on bank 1
	task automatic t_in();
		i_eng.in_token(2'h3, go, nak, len);
		chk("nak off ep", 32'h0000_0001, 32'({go, nak}));
		wr(ufi_pkg::ADDR_EP_SELECT, 32'h0000_0002);
		wr(ufi_pkg::ADDR_EP_CONTROL, 32'h0000_0002);
		i_eng.in_token(2'h2, go, nak, len);
		chk("nak not ready", 32'h0000_0001, 32'({go, nak}));
		wr(ufi_pkg::ADDR_FIFO_DATA, 32'h0000_0011);
		wr(ufi_pkg::ADDR_FIFO_DATA, 32'h0000_0022);
		rd("count", ufi_pkg::ADDR_RX_COUNT, 32'h0000_0000);
		wr(ufi_pkg::ADDR_EP_STATUS, 32'h0000_0001);
		rd("bank", ufi_pkg::ADDR_EP_STATUS, 32'h0000_0004);
		wr(ufi_pkg::ADDR_FIFO_RESET, 32'h0000_0004);
		wr(ufi_pkg::ADDR_FIFO_RESET, 32'h0000_0000);
		rd("bank kept", ufi_pkg::ADDR_EP_STATUS, 32'h0000_0004);
		i_eng.in_token(2'h2, go, nak, len);
		chk("go", 32'h0000_0002, 32'({go, nak}));
		chk("in_len", 32'h0000_0002, 32'(len));
		i_eng.tx_fetch(b);
		chk("tx byte", 32'h0000_0011, 32'(b));
		i_eng.tx_fetch(b);
		chk("tx byte", 32'h0000_0022, 32'(b));
		wr(ufi_pkg::ADDR_INT_MASK, 32'h0000_0004);
		i_eng.ack(3);
		@(negedge aclk);
		chk("irq", 32'h0000_0001, 32'(irq));
		chk("toggle", 32'h0000_0004, 32'(data_toggle));
		rd("complete", ufi_pkg::ADDR_EP_STATUS, 32'h0000_0006);
		i_eng.in_token(2'h2, go, nak, len);
		chk("nak bank 1", 32'h0000_0001, 32'({go, nak}));
		wr(ufi_pkg::ADDR_EP_STATUS, 32'h0000_0002);
		rd("cleared", ufi_pkg::ADDR_EP_STATUS, 32'h0000_0004);
		wr(ufi_pkg::ADDR_INT_STATUS, 32'h0000_0004);
		@(negedge aclk);
		chk("irq off", 32'h0000_0000, 32'(irq));
	endtask

	// counts, verdict, end
	task automatic summarize();
		$display("compares %0d mismatches %0d", cmp_count, bad_count);
		if (bad_count == 0 && cmp_count > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// hang guard
	always @(posedge aclk)
	begin
		cyc++;
		if (cyc == 3000)
		begin
			bad_count++;
			summarize();
		end
	end

	// reset, then the scenarios
	initial
	begin
		aclk = 1'b0;
		aresetn = 1'b0;
		{awaddr, awvalid, wdata, wvalid, bready, araddr, arvalid, rready} = '0;
		wstrb = 4'hf;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		t_reset();
		t_out();
		t_in();
		summarize();
	end
endmodule // usb_endpoint_fifo_interface_test
`default_nettype wire
